// file: inc/pwr_mode_pkg.sv
package pwr_mode_pkg;

  localparam int unsigned POWER_CONTROL_REG_IDLE_BIT    = 0;
  localparam int unsigned POWER_CONTROL_REG_STOP_BIT    = 1;
  localparam int unsigned OSC_SUSPEND_BIT  = 5;
  localparam logic [15:0] RESET_VECTOR     = 16'h0000;
  localparam int unsigned CLK_FREQ_HZ      = 10_000_000;
  localparam int unsigned MCD_TIMEOUT_US   = 100;
  localparam int unsigned MCD_TIMEOUT_CYC  = (MCD_TIMEOUT_US * (CLK_FREQ_HZ / 1_000_000));

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_IDLE,
    MODE_STOP,
    MODE_SUSPEND
  } pwr_mode_type;

endpackage

// file: hdl/wake_sync.sv
`timescale 1ns/100ps
module wake_sync
  import pwr_mode_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic level_in,
  output logic      rise_pulse
);
  logic prev_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prev_r     <= 1'b0;
      rise_pulse <= 1'b0;
    end else begin
      prev_r     <= level_in;
      rise_pulse <= level_in & ~prev_r;
    end
  end
endmodule // wake_sync

// file: hdl/stop_timeout.sv
`timescale 1ns/100ps
module stop_timeout
  import pwr_mode_pkg::*;
#(
  parameter int unsigned LIMIT = MCD_TIMEOUT_CYC
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic run,
  output logic      expired
);
  logic [15:0] cnt_r;

  always_ff @(posedge core_clk) begin
    if (rst || !run) begin
      cnt_r   <= 16'h0000;
      expired <= 1'b0;
    end else if (cnt_r == 16'(LIMIT - 1)) begin
      expired <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
endmodule // stop_timeout

// file: hdl/power_mode_control.sv
`timescale 1ns/100ps
// What this block does
// - three low-power modes offered: idle, stop and suspend
// - idle bit written: cpu halts after the writing instruction completes
// - idle stops only the cpu clock; peripherals and memory keep running
// - enabled interrupt or reset ends idle; interrupt clears idle bit
// - after idle wake the pending interrupt is serviced, then next instruction
// - reset ending idle gives normal reset sequence from 0x0000
// - watchdog keeps running in idle and may reset out of it
// - stop bit halts internal oscillator, cpu and digital peripherals
// - in stop all interrupts and timers idle except missing clock detector
// - stop leaves analog peripheral enables untouched
// - stop ends only on reset, then runs from 0x0000
// - enabled missing clock detector resets device during stop after timeout
// - suspend bit halts cpu and fast oscillator, state retained
// - in suspend port match, interrupt gate, internal oscillator and slow-clocked timer 3 stay active
// - suspend ends on port match, timer 3 overflow, comparator low, reset
// - non-reset suspend wake resumes at the following instruction
// - interrupt-configured wake event is serviced at once after suspend
// - reset ending suspend gives normal reset sequence from 0x0000
// - idle and stop bits always read as zero; write only triggers
module power_mode_control
  import pwr_mode_pkg::*;
#(
  parameter int unsigned MCD_CYCLES = MCD_TIMEOUT_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        power_control_reg_wr,
  input  wire logic [7:0]  power_control_reg_wdata,
  input  wire logic        osc_wr,
  input  wire logic [7:0]  osc_wdata,
  input  wire logic        instr_done,
  input  wire logic        irq_pending,
  input  wire logic        port_match,
  input  wire logic        t3_overflow,
  input  wire logic        t3_slow_clk,
  input  wire logic        cmp_low,
  input  wire logic        cmp_wake_en,
  input  wire logic        wdt_enable,
  input  wire logic        wdt_expired,
  input  wire logic        mcd_enable,
  output logic       [7:0] power_control_reg_rdata,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             int_osc_en,
  output logic             hf_osc_en,
  output logic             irq_gate_en,
  output logic             port_match_en,
  output logic             t3_clk_en,
  output logic             wdt_run,
  output logic             mcd_run,
  output logic             internal_reset,
  output logic             wake_irq_service,
  output logic       [1:0] mode_status
);

  ////////////////////////////////////////////////////////////////////////////
  // pending entry requests and mode state
  pwr_mode_type mode_r;
  pwr_mode_type mode_nxt;
  pwr_mode_type mode_gate;
  logic         idle_req_r;
  logic         stop_req_r;
  logic         susp_req_r;
  logic [5:0]   gp_flags_r;
  logic         cmp_rise;
  logic         mcd_expired;
  logic         susp_wake;
  logic         idle_wake;
  logic         reset_cause;

  ////////////////////////////////////////////////////////////////////////////
  // comparator edge and stop timeout helpers
  wake_sync u_cmp_sync (
    .core_clk   (core_clk),
    .rst        (rst),
    .level_in   (cmp_low & cmp_wake_en),
    .rise_pulse (cmp_rise)
  );

  stop_timeout #(
    .LIMIT (MCD_CYCLES)
  ) u_mcd (
    .core_clk (core_clk),
    .rst      (rst),
    .run      (mode_r == MODE_STOP && mcd_enable),
    .expired  (mcd_expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // wake and internal reset causes

  assign idle_wake   = irq_pending;
  assign susp_wake   = port_match | (t3_overflow & t3_slow_clk) | cmp_rise
                       | (cmp_low & cmp_wake_en);
  assign reset_cause = (wdt_enable & wdt_expired & (mode_r != MODE_STOP))
                       | mcd_expired;

  ////////////////////////////////////////////////////////////////////////////
  // write capture: mode bits arm a request, read back as zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      idle_req_r <= 1'b0;
    end else if (power_control_reg_wr) begin
      idle_req_r <= power_control_reg_wdata[POWER_CONTROL_REG_IDLE_BIT];
    end else if (instr_done) begin
      idle_req_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      stop_req_r <= 1'b0;
    end else if (power_control_reg_wr) begin
      stop_req_r <= power_control_reg_wdata[POWER_CONTROL_REG_STOP_BIT];
    end else if (instr_done) begin
      stop_req_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      susp_req_r <= 1'b0;
    end else if (osc_wr) begin
      susp_req_r <= osc_wdata[OSC_SUSPEND_BIT];
    end else if (instr_done) begin
      susp_req_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      gp_flags_r <= 6'h00;
    end else if (power_control_reg_wr) begin
      gp_flags_r <= power_control_reg_wdata[7:2];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      power_control_reg_rdata <= 8'h00;
    end else begin
      power_control_reg_rdata <= {(power_control_reg_wr ? power_control_reg_wdata[7:2] : gp_flags_r), 2'b00};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode sequencing
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_RUN: begin
        if (instr_done) begin
          if (stop_req_r) begin
            mode_nxt = MODE_STOP;
          end else if (idle_req_r) begin
            mode_nxt = MODE_IDLE;
          end else if (susp_req_r) begin
            mode_nxt = MODE_SUSPEND;
          end
        end
      end
      MODE_IDLE: begin
        if (idle_wake) begin
          mode_nxt = MODE_RUN;
        end
      end
      MODE_STOP: begin
        mode_nxt = MODE_STOP;
      end
      MODE_SUSPEND: begin
        if (susp_wake) begin
          mode_nxt = MODE_RUN;
        end
      end
      default: begin
        mode_nxt = MODE_RUN;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode register and internal reset report

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_r <= MODE_RUN;
    end else if (reset_cause) begin
      mode_r <= MODE_RUN;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      internal_reset <= 1'b0;
    end else begin
      internal_reset <= reset_cause;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wake_irq_service <= 1'b0;
    end else begin
      wake_irq_service <= (mode_r == MODE_IDLE && idle_wake && !reset_cause)
                          | (mode_r == MODE_SUSPEND && susp_wake && irq_pending
                             && !reset_cause);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock and domain gating from the next mode; mcd_run follows mcd_enable alone
  assign mode_gate = reset_cause ? MODE_RUN : mode_nxt;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_status <= 2'(MODE_RUN);
    end else begin
      mode_status <= 2'(mode_gate);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cpu_clk_en <= 1'b1;
    end else begin
      cpu_clk_en <= (mode_gate == MODE_RUN);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      periph_clk_en <= 1'b1;
    end else begin
      periph_clk_en <= (mode_gate == MODE_RUN) || (mode_gate == MODE_IDLE);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      int_osc_en <= 1'b1;
    end else begin
      int_osc_en <= (mode_gate != MODE_STOP);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hf_osc_en <= 1'b1;
    end else begin
      hf_osc_en <= (mode_gate != MODE_STOP) && (mode_gate != MODE_SUSPEND);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_gate_en <= 1'b1;
    end else begin
      irq_gate_en <= (mode_gate != MODE_STOP);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      port_match_en <= 1'b1;
    end else begin
      port_match_en <= (mode_gate != MODE_STOP);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      t3_clk_en <= 1'b1;
    end else begin
      t3_clk_en <= (mode_gate == MODE_RUN) || (mode_gate == MODE_IDLE)
                   || (mode_gate == MODE_SUSPEND && t3_slow_clk);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wdt_run <= 1'b1;
    end else begin
      wdt_run <= wdt_enable && (mode_gate != MODE_STOP) && (mode_gate != MODE_SUSPEND);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mcd_run <= 1'b1;
    end else begin
      mcd_run <= mcd_enable;
    end
  end

endmodule // power_mode_control

// file: dv/power_mode_control_assertions.sv
`timescale 1ns/100ps
module power_mode_control_assertions
  import pwr_mode_pkg::*;
#(
  parameter int unsigned MCD_CYCLES = MCD_TIMEOUT_CYC
) (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       power_control_reg_wr,
  input wire logic [7:0] power_control_reg_wdata,
  input wire logic       instr_done,
  input wire logic       irq_pending,
  input wire logic       port_match,
  input wire logic       wdt_enable,
  input wire logic       wdt_expired,
  input wire logic       mcd_enable,
  input wire logic [7:0] power_control_reg_rdata,
  input wire logic       cpu_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       int_osc_en,
  input wire logic       hf_osc_en,
  input wire logic       irq_gate_en,
  input wire logic       port_match_en,
  input wire logic       wdt_run,
  input wire logic       internal_reset,
  input wire logic       wake_irq_service,
  input wire logic [1:0] mode_status
);
  localparam int TO_WIN = MCD_CYCLES + 4;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  sequence idle_req_s;
    power_control_reg_wr && power_control_reg_wdata[1:0] == 2'h1 && mode_status == MODE_RUN ##1 instr_done && !power_control_reg_wr;
  endsequence
  sequence stop_left_s;
    mode_status == MODE_STOP && !internal_reset ##1 mode_status != MODE_STOP;
  endsequence
  AST_RDATA_LOW: assert property (power_control_reg_rdata[1:0] == 2'h0)
    else $error("select bits read nonzero");
  AST_IDLE_ENTRY: assert property (idle_req_s |=> mode_status == MODE_IDLE && !cpu_clk_en)
    else $error("idle not entered");
  AST_IDLE_GATE: assert property (mode_status == MODE_IDLE |-> !cpu_clk_en && periph_clk_en && int_osc_en)
    else $error("idle gating wrong");
  AST_IDLE_WAKE: assert property (mode_status == MODE_IDLE && irq_pending && !wdt_expired |=>
    mode_status == MODE_RUN && cpu_clk_en && wake_irq_service) else $error("idle wake wrong");
  AST_WDT_IDLE: assert property (mode_status == MODE_IDLE && wdt_enable && wdt_expired |-> ##[1:2] internal_reset)
    else $error("watchdog idle reset missing");
  AST_STOP_GATE: assert property (mode_status == MODE_STOP |->
    !(cpu_clk_en || periph_clk_en || int_osc_en || irq_gate_en || wdt_run)) else $error("stop gating wrong");
  AST_STOP_EXIT: assert property (stop_left_s |-> internal_reset)
    else $error("stop left without reset");
  AST_MCD_TIMEOUT: assert property ($rose(mode_status == MODE_STOP) && mcd_enable |-> ##[1:TO_WIN] internal_reset)
    else $error("clock detector timeout missing");
  AST_SUSP_GATE: assert property (mode_status == MODE_SUSPEND |-> !cpu_clk_en && !hf_osc_en && port_match_en)
    else $error("suspend gating wrong");
  AST_SUSP_WAKE: assert property ($rose(port_match) && mode_status == MODE_SUSPEND |-> ##[1:4] mode_status == MODE_RUN)
    else $error("suspend wake missing");
endmodule // power_mode_control_assertions
bind power_mode_control power_mode_control_assertions #(.MCD_CYCLES(MCD_CYCLES)) i_chk (.*);

// file: dv/cpu_wake_model.sv
`timescale 1ns/100ps
module cpu_wake_model (
  input  wire logic       core_clk,
  input  wire logic       wdt_run,
  input  wire logic       t3_clk_en,
  input  wire logic       irq_gate_en,
  input  wire logic       port_match_en,
  output logic            power_control_reg_wr,
  output logic [7:0]      power_control_reg_wdata,
  output logic            osc_wr,
  output logic [7:0]      osc_wdata,
  output logic            instr_done,
  output logic            irq_pending,
  output logic            port_match,
  output logic            t3_overflow,
  output logic            t3_slow_clk,
  output logic            cmp_low,
  output logic            cmp_wake_en,
  output logic            wdt_enable,
  output logic            wdt_expired,
  output logic            mcd_enable
);
  logic irq_req_r;
  logic port_req_r;
  logic t3_fire_r;
  logic wdt_fire_r;

  // far-side irq, port match, timer 3 and watchdog sources only fire while the block lets their domain run; cmp_low is not gated
  assign irq_pending = irq_req_r & irq_gate_en;
  assign port_match  = port_req_r & port_match_en;
  assign t3_overflow = t3_fire_r & t3_clk_en;
  assign wdt_expired = wdt_fire_r & wdt_run;

  initial begin
    {power_control_reg_wr, osc_wr, instr_done, power_control_reg_wdata, osc_wdata} = 19'h0;
    {wdt_enable, mcd_enable, t3_slow_clk, cmp_wake_en, irq_req_r, port_req_r, t3_fire_r, cmp_low,
     wdt_fire_r} = 9'h100;
  end
  // write, then the completing multi-byte instruction
  task automatic sw_write(input logic osc, input logic [7:0] d);
    @(posedge core_clk);
    {power_control_reg_wr, osc_wr} <= {!osc, osc};
    {power_control_reg_wdata, osc_wdata} <= osc ? {8'h00, d} : {d, 8'h00};
    @(posedge core_clk);
    {power_control_reg_wr, osc_wr, instr_done} <= 3'h1;
    {power_control_reg_wdata, osc_wdata} <= ~{power_control_reg_wdata, osc_wdata};
    @(posedge core_clk);
    instr_done <= 1'b0;
  endtask
  // watchdog/detector enables, wake sources and fire lines all set together
  task automatic set_lines(input logic [8:0] v);
    @(posedge core_clk);
    {wdt_enable, mcd_enable, t3_slow_clk, cmp_wake_en, irq_req_r, port_req_r, t3_fire_r, cmp_low,
     wdt_fire_r} <= v;
  endtask
endmodule // cpu_wake_model

// file: dv/power_mode_control_tb_top.sv
`timescale 1ns/100ps
module power_mode_control_tb_top;
  import pwr_mode_pkg::*;
  localparam int unsigned DET_CYC = 10;
  logic       core_clk, rst, power_control_reg_wr, osc_wr, instr_done, irq_pending, port_match, t3_overflow;
  logic       t3_slow_clk, cmp_low, cmp_wake_en, wdt_enable, wdt_expired, mcd_enable, mcd_run;
  logic       cpu_clk_en, periph_clk_en, int_osc_en, hf_osc_en, irq_gate_en, port_match_en;
  logic       t3_clk_en, wdt_run, internal_reset, wake_irq_service;
  logic [7:0] power_control_reg_wdata, osc_wdata, power_control_reg_rdata;
  logic [1:0] mode_status;
  int         err_count, samples_checked;
  wire  [7:0] st = {mode_status, cpu_clk_en, periph_clk_en, int_osc_en, irq_gate_en, port_match_en, wdt_run};
  power_mode_control #(.MCD_CYCLES(DET_CYC)) i_dut (.*);
  cpu_wake_model i_sw (.*);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic do_reset(input int n);
    i_sw.set_lines(9'h100);
    rst <= 1'b1;
    repeat (n) @(posedge core_clk);
    rst <= 1'b0;
    tick(1);
    check(st, 8'h3f);
    check({power_control_reg_rdata[7:1], internal_reset}, 8'h00);
  endtask
  task automatic expect_rst(input int lim);
    int n;
    n = 0;
    while (internal_reset !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
    check({7'h0, internal_reset}, 8'h01);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_idle();
    i_sw.sw_write(1'b0, 8'h05);
    tick(0);
    check(st, 8'h5f);
    check(power_control_reg_rdata, 8'h04);
    check({5'h0, hf_osc_en, t3_clk_en, mcd_run}, 8'h06);
    i_sw.set_lines(9'h108);
    tick(3);
    check(st, 8'h5f);
    i_sw.set_lines(9'h110);
    tick(1);
    check({st[7:6], 5'h0, wake_irq_service}, 8'h01);
    i_sw.set_lines(9'h100);
    $display("idle test done");
  endtask
  task automatic t_wdt();
    i_sw.set_lines(9'h001);
    i_sw.sw_write(1'b0, 8'h01);
    tick(3);
    check(st, 8'h5e);
    check({7'h0, internal_reset}, 8'h00);
    i_sw.set_lines(9'h101);
    expect_rst(3);
    do_reset(3);
    $display("watchdog test done");
  endtask
  task automatic t_stop();
    i_sw.set_lines(9'h180);
    i_sw.sw_write(1'b0, 8'h03);
    tick(0);
    check(st, 8'h80);
    check({5'h0, hf_osc_en, t3_clk_en, mcd_run}, 8'h01);
    i_sw.set_lines(9'h1ba);
    tick(2);
    check(st, 8'h80);
    expect_rst(DET_CYC + 4);
    do_reset(3);
    $display("stop test done");
  endtask
  task automatic t_susp();
    logic [8:0] src [3] = '{9'h108, 9'h144, 9'h122};
    for (int i = 0; i < 3; i++) begin
      i_sw.set_lines(9'h102);
      i_sw.sw_write(1'b1, 8'h20);
      tick(0);
      check({3'h0, mode_status, cpu_clk_en, hf_osc_en, port_match_en}, 8'h19);
      check({6'h0, t3_clk_en, mcd_run}, 8'h00);
      i_sw.set_lines(9'h112);
      tick(3);
      check({6'h0, mode_status}, 8'h03);
      i_sw.set_lines(src[i]);
      tick(4);
      check({6'h0, mode_status}, 8'h00);
    end
    $display("suspend test done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    err_count = 0;
    samples_checked = 0;
    do_reset(20);
    t_idle();
    t_wdt();
    t_stop();
    t_susp();
    results();
  end
  initial begin
    #200_000;
    err_count++;
    results();
  end
endmodule // power_mode_control_tb_top
